// >>> design/fac_pkg.sv
/*
 * Types shared by the fan acoustic ramp control design files.
 * Assumes nothing of its surroundings.
 */
package fac_pkg;
    // Register byte and duty value
    typedef logic [7:0] fac_byte_t;
    // Step increment per time slot
    typedef logic [5:0] fac_step_t;
    // Ramp code field
    typedef logic [2:0] fac_code_t;
endpackage

// >>> design/fac_ramp.sv
/*
 * One fan drive duty ramp: steps the duty towards its target once per
 * slot tick, or follows the target at once while smoothing is off.
 * Assumes tick_in is a one-cycle enable pulse in the clk_in domain.
 */
module fac_ramp #(
    parameter int W = 8,
    parameter int SW = 6
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Control
    input wire logic tick_in,
    input wire logic smooth_in,
    input wire logic [SW-1:0] step_in,
    input wire logic [W-1:0] target_in,
    // Result
    output logic [W-1:0] duty_out
);
    logic up; // Target lies above duty
    logic [W-1:0] gap; // Distance to target
    logic [W-1:0] step_w; // Step widened to duty width
    logic [W-1:0] move; // Clipped move this slot

    // ----------------------------------------
    // Move size
    // ----------------------------------------
    // Clip to the gap so the ramp never overshoots
    always_comb begin
        up = target_in > duty_out;
        gap = up ? target_in - duty_out : duty_out - target_in;
        step_w = W'(step_in);
        move = (gap > step_w) ? step_w : gap;
    end

    // ----------------------------------------
    // Duty register
    // ----------------------------------------
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            duty_out <= '0;
        end else if (!smooth_in) begin
            duty_out <= target_in; // No smoothing: jump
        end else if (tick_in) begin
            duty_out <= up ? duty_out + move : duty_out - move; // [R12]
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_jump_direct: assert property (@(posedge clk_in) disable iff (rst_in) // [R12]
        !smooth_in |=> duty_out == $past(target_in))
        else $error("duty did not follow target with smoothing off");
    a_hold_slot: assert property (@(posedge clk_in) disable iff (rst_in) // [R12]
        smooth_in && !tick_in |=> $stable(duty_out))
        else $error("duty moved between slot ticks");
    a_step_bound: assert property (@(posedge clk_in) disable iff (rst_in) // [R12]
        smooth_in && tick_in |=> duty_out == ($past(up) ? $past(duty_out) + $past(move)
                                              : $past(duty_out) - $past(move))
        && ($past(gap) == '0 || duty_out != $past(duty_out)))
        else $error("ramp step wrong size");
endmodule

// >>> design/fac_regs.svh
/*
 * Register offsets, field positions, reset values and timing figures
 * for the fan acoustic ramp control block.
 * Assumes an 8-bit register port and a 20 MHz system clock.
 */
`ifndef FAC_REGS_SVH
`define FAC_REGS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define FAC_ADDR_CFG6 8'h10
`define FAC_ADDR_DUTY0 8'h30
`define FAC_ADDR_DUTY1 8'h31
`define FAC_ADDR_DUTY2 8'h32
`define FAC_ADDR_CFG1 8'h40
`define FAC_ADDR_ACOU1 8'h62
`define FAC_ADDR_ACOU2 8'h63

// ----------------------------------------
// Reset values
// ----------------------------------------
`define FAC_RST_BYTE 8'h00
`define FAC_RST_TACH 4'hc

// ----------------------------------------
// Field positions
// ----------------------------------------
`define FAC_CODE_MSB 2
`define FAC_CODE_LSB 0
`define FAC_SMOOTH_BIT 3
`define FAC_SYNC_BIT 4
`define FAC_FLOOR_BIT 5
`define FAC_SLOT_BIT 7
`define FAC_SLOW_REM1_BIT 0
`define FAC_SLOW_LOCAL_BIT 1
`define FAC_LOCK_BIT 1

// ----------------------------------------
// Speed input synchronisation patterns
// ----------------------------------------
`define FAC_TACH_SYNC_ALL 4'he
`define FAC_TACH_SYNC_TWO 4'hc

// ----------------------------------------
// Step increments per ramp code
// ----------------------------------------
`define FAC_STEP0 6'h01
`define FAC_STEP1 6'h02
`define FAC_STEP2 6'h03
`define FAC_STEP3 6'h04
`define FAC_STEP4 6'h08
`define FAC_STEP5 6'h0c
`define FAC_STEP6 6'h18
`define FAC_STEP7 6'h30

// ----------------------------------------
// Timing figures
// ----------------------------------------
`define FAC_CLK_KHZ 20000
`define FAC_FULL_FAST_MS 37500
`define FAC_FULL_SLOW_MS 52200
`define FAC_FULL_STEPS 255
`define FAC_SLOW_LAST 2'h3

`endif

// >>> design/fac_top.sv
/*
 * Fan acoustic ramp control: acoustic enhancement registers, ramp time
 * slot divider, floor selection below the start temperature, speed
 * input synchronisation select and three duty ramps.
 * Assumes the fan loop supplies targets, minimum duties, the automatic
 * mode flag and per-output below-start and source flags, all
 * synchronous to CLK_IN.
 */
// Local design decision: the plain strobed port.
// Function
// R1 - remote-one smoothing enable ramps remote-driven changes
// R2 - sync set: speed inputs two-four follow drive three
// R3 - sync clear: only inputs three, four follow
// R4 - drive one floor: off or minimum duty
// R5 - drive two floor: off or minimum duty
// R6 - drive three floor: off or minimum duty
// R7 - lock bit makes register read-only
// R8 - slowdown bit divides channel ramp rate four
// R9 - second register at 0x63, reset zero
// R10 - fast slot: full ramp 37.5 s
// R11 - slow slot: full ramp 52.2 s
// R12 - smoothing steps duty once per slot
`include "fac_regs.svh"

module fac_top #(
    parameter int N = 3,
    parameter int SLOT_W = 24,
    parameter logic [SLOT_W-1:0] SLOT_FAST_CYC =
        SLOT_W'(`FAC_FULL_FAST_MS * `FAC_CLK_KHZ / `FAC_FULL_STEPS),
    parameter logic [SLOT_W-1:0] SLOT_SLOW_CYC =
        SLOT_W'(`FAC_FULL_SLOW_MS * `FAC_CLK_KHZ / `FAC_FULL_STEPS)
) (
    // Clock and reset
    input wire logic CLK_IN,
    input wire logic SYS_RST_IN,
    // Register port
    input wire logic [7:0] ADDR_IN,
    input wire logic [7:0] WR_DATA_IN,
    input wire logic WR_EN_IN,
    input wire logic RD_EN_IN,
    output logic [7:0] RD_DATA_OUT,
    // Fan loop inputs
    input wire logic AUTO_MODE_IN,
    input wire logic [N-1:0] BELOW_START_IN,
    input wire logic [N-1:0] CTRL_REMOTE1_IN,
    input wire logic [N-1:0] CTRL_LOCAL_IN,
    input wire logic [N-1:0][7:0] TARGET_DUTY_IN,
    input wire logic [N-1:0][7:0] MIN_DUTY_IN,
    // Fan drive and speed sync outputs
    output logic [N-1:0][7:0] DUTY_OUT,
    output logic [3:0] TACH_SYNC_OUT
);
    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    fac_pkg::fac_byte_t acou1; // First acoustic fields
    fac_pkg::fac_byte_t acou2; // Second acoustic register
    fac_pkg::fac_byte_t cfg1; // Configuration one
    fac_pkg::fac_byte_t cfg6; // Configuration six
    fac_pkg::fac_byte_t next_rd; // Read mux result
    logic locked; // Lock bit, sticky
    logic wr_acou1; // Decoded writes
    logic wr_acou2;
    logic wr_cfg1;
    logic wr_cfg6;
    logic [SLOT_W-1:0] slot_len; // Selected slot length
    logic [SLOT_W-1:0] slot_cnt; // Slot divider
    logic base_tick; // One pulse per slot
    logic [1:0] quarter_cnt; // Counts base slots
    logic quarter_tick; // One pulse per four slots
    logic [N-1:0] smooth; // Smoothing active per output
    logic [N-1:0] slow; // Slowdown per output
    logic [N-1:0] tick; // Slot pulse per output
    fac_pkg::fac_step_t step [N]; // Step per output
    fac_pkg::fac_byte_t eff_target [N]; // Target after floor

    // Lock state read straight from configuration one
    assign locked = cfg1[`FAC_LOCK_BIT];

    // ----------------------------------------
    // Write decode
    // ----------------------------------------
    // Locked acoustic registers drop writes silently
    always_comb begin
        wr_acou1 = WR_EN_IN && ADDR_IN == `FAC_ADDR_ACOU1 && !locked; // [R7]
        wr_acou2 = WR_EN_IN && ADDR_IN == `FAC_ADDR_ACOU2 && !locked; // [R7]
        wr_cfg1 = WR_EN_IN && ADDR_IN == `FAC_ADDR_CFG1;
        wr_cfg6 = WR_EN_IN && ADDR_IN == `FAC_ADDR_CFG6;
    end

    // ----------------------------------------
    // Acoustic registers
    // ----------------------------------------
    // Second register, power-on zero
    always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            acou2 <= `FAC_RST_BYTE; // [R9]
        end else if (wr_acou2) begin
            acou2 <= WR_DATA_IN; // [R9]
        end
    end

    // First register fields, same lock
    always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            acou1 <= `FAC_RST_BYTE;
        end else if (wr_acou1) begin
            acou1 <= WR_DATA_IN;
        end
    end

    // ----------------------------------------
    // Configuration registers
    // ----------------------------------------
    // Lock only clears at reset, so software cannot undo it
    always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            cfg1 <= `FAC_RST_BYTE;
        end else if (wr_cfg1) begin
            cfg1 <= WR_DATA_IN; // Plain write
            if (locked) begin
                cfg1[`FAC_LOCK_BIT] <= 1'b1; // A set lock stays set [R7]
            end
        end
    end

    // Slot select and slowdown bits
    always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            cfg6 <= `FAC_RST_BYTE;
        end else if (wr_cfg6) begin
            cfg6 <= WR_DATA_IN;
        end
    end

    // ----------------------------------------
    // Read port
    // ----------------------------------------
    // Unmapped offsets read as zero
    always_comb begin
        case (ADDR_IN)
            `FAC_ADDR_ACOU1: next_rd = acou1;
            `FAC_ADDR_ACOU2: next_rd = acou2;
            `FAC_ADDR_CFG1: next_rd = cfg1;
            `FAC_ADDR_CFG6: next_rd = cfg6;
            `FAC_ADDR_DUTY0: next_rd = DUTY_OUT[0];
            `FAC_ADDR_DUTY1: next_rd = DUTY_OUT[1];
            `FAC_ADDR_DUTY2: next_rd = DUTY_OUT[2];
            default: next_rd = `FAC_RST_BYTE;
        endcase
    end

    // Data stand for one cycle only, zero otherwise
    always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            RD_DATA_OUT <= `FAC_RST_BYTE;
        end else begin
            RD_DATA_OUT <= RD_EN_IN ? next_rd : `FAC_RST_BYTE;
        end
    end

    // ----------------------------------------
    // Speed input synchronisation select
    // ----------------------------------------
    // Registered so the output never glitches on a write
    always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            TACH_SYNC_OUT <= `FAC_RST_TACH;
        end else if (acou2[`FAC_SYNC_BIT]) begin
            TACH_SYNC_OUT <= `FAC_TACH_SYNC_ALL; // [R2]
        end else begin
            TACH_SYNC_OUT <= `FAC_TACH_SYNC_TWO; // [R3]
        end
    end

    // ----------------------------------------
    // Ramp time slot divider
    // ----------------------------------------
    // Slot length picks the full-scale ramp time
    always_comb begin
        slot_len = cfg6[`FAC_SLOT_BIT] ? SLOT_SLOW_CYC : SLOT_FAST_CYC; // [R10] [R11]
        base_tick = slot_cnt >= slot_len - SLOT_W'(1);
        quarter_tick = base_tick && quarter_cnt == `FAC_SLOW_LAST; // [R8]
    end

    // Compare with >= so a shorter slot chosen mid-count ends at once
    always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            slot_cnt <= '0;
        end else if (base_tick) begin
            slot_cnt <= '0;
        end else begin
            slot_cnt <= slot_cnt + SLOT_W'(1);
        end
    end

    // Every fourth slot, for slowed channels
    always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            quarter_cnt <= 2'h0;
        end else if (base_tick) begin
            quarter_cnt <= quarter_cnt + 2'h1; // [R8]
        end
    end

    // ----------------------------------------
    // Step increment lookup
    // ----------------------------------------
    function automatic fac_pkg::fac_step_t step_of(input fac_pkg::fac_code_t code);
        case (code)
            3'h0: step_of = `FAC_STEP0;
            3'h1: step_of = `FAC_STEP1;
            3'h2: step_of = `FAC_STEP2;
            3'h3: step_of = `FAC_STEP3;
            3'h4: step_of = `FAC_STEP4;
            3'h5: step_of = `FAC_STEP5;
            3'h6: step_of = `FAC_STEP6;
            default: step_of = `FAC_STEP7;
        endcase
    endfunction

    // ----------------------------------------
    // Per-output control and ramps
    // ----------------------------------------
    // Remote one wins if both source flags are raised
    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_out
            always_comb begin
                if (CTRL_REMOTE1_IN[i]) begin
                    smooth[i] = acou2[`FAC_SMOOTH_BIT]; // [R1]
                    slow[i] = cfg6[`FAC_SLOW_REM1_BIT]; // [R8]
                    step[i] = step_of(acou2[`FAC_CODE_MSB:`FAC_CODE_LSB]); // [R10]
                end else begin
                    smooth[i] = CTRL_LOCAL_IN[i] && acou1[`FAC_SMOOTH_BIT];
                    slow[i] = CTRL_LOCAL_IN[i] && cfg6[`FAC_SLOW_LOCAL_BIT];
                    step[i] = step_of(acou1[`FAC_CODE_MSB:`FAC_CODE_LSB]);
                end
                tick[i] = slow[i] ? quarter_tick : base_tick; // [R8]
                // Below start minus hysteresis: off or minimum
                if (AUTO_MODE_IN && BELOW_START_IN[i]) begin
                    eff_target[i] = acou2[`FAC_FLOOR_BIT + i] ? MIN_DUTY_IN[i] : `FAC_RST_BYTE; // [R4] [R5] [R6]
                end else begin
                    eff_target[i] = TARGET_DUTY_IN[i];
                end
            end

            fac_ramp #(
                .W(8),
                .SW(6)
            ) u_ramp (
                .clk_in(CLK_IN),
                .rst_in(SYS_RST_IN),
                .tick_in(tick[i]),
                .smooth_in(smooth[i]),
                .step_in(step[i]),
                .target_in(eff_target[i]),
                .duty_out(DUTY_OUT[i]) // [R12]
            );
        end
    endgenerate

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    // All checks share the one clock and sleep through reset
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (SYS_RST_IN);

    // ----------------------------------------
    // Register port checks
    // ----------------------------------------
    // A write to the second register with the lock closed
    sequence s_locked_write;
        locked && WR_EN_IN && ADDR_IN == `FAC_ADDR_ACOU2;
    endsequence
    // The same write with the lock open
    sequence s_open_write;
        !locked && WR_EN_IN && ADDR_IN == `FAC_ADDR_ACOU2;
    endsequence
    // A read of the second register
    sequence s_second_read;
        RD_EN_IN && ADDR_IN == `FAC_ADDR_ACOU2;
    endsequence

    a_lock_ignore: assert property (s_locked_write |=> $stable(acou2) && locked) // [R7]
        else $error("locked register changed on write");

    // Only reset may open the lock again
    a_lock_sticky: assert property (locked |=> locked) // [R7]
        else $error("lock bit cleared without reset");

    // A read straight after a write returns the written byte
    a_second_write: assert property (s_open_write ##1 s_second_read // [R9]
        |=> RD_DATA_OUT == $past(WR_DATA_IN, 2))
        else $error("second register readback wrong");

    // ----------------------------------------
    // Speed sync checks
    // ----------------------------------------
    // Pattern follows the sync bit one cycle late
    a_sync_all: assert property ($past(acou2[`FAC_SYNC_BIT]) |-> TACH_SYNC_OUT == `FAC_TACH_SYNC_ALL) // [R2]
        else $error("sync set but pattern wrong");

    a_sync_two: assert property (!$past(acou2[`FAC_SYNC_BIT]) |-> TACH_SYNC_OUT == `FAC_TACH_SYNC_TWO) // [R3]
        else $error("sync clear but pattern wrong");

    // ----------------------------------------
    // Floor checks
    // ----------------------------------------
    // Floor applies only in automatic mode below start
    a_floor_one: assert property (AUTO_MODE_IN && BELOW_START_IN[0] |-> // [R4]
        eff_target[0] == (acou2[`FAC_FLOOR_BIT] ? MIN_DUTY_IN[0] : `FAC_RST_BYTE))
        else $error("drive one floor wrong");

    a_floor_two: assert property (AUTO_MODE_IN && BELOW_START_IN[1] |-> // [R5]
        eff_target[1] == (acou2[`FAC_FLOOR_BIT + 1] ? MIN_DUTY_IN[1] : `FAC_RST_BYTE))
        else $error("drive two floor wrong");

    a_floor_three: assert property (AUTO_MODE_IN && BELOW_START_IN[2] |-> // [R6]
        eff_target[2] == (acou2[`FAC_FLOOR_BIT + 2] ? MIN_DUTY_IN[2] : `FAC_RST_BYTE))
        else $error("drive three floor wrong");

    // ----------------------------------------
    // Ramp and slot checks
    // ----------------------------------------
    // A smoothed remote drive holds between slot ticks
    a_remote_smooth: assert property (CTRL_REMOTE1_IN[0] && acou2[`FAC_SMOOTH_BIT] // [R1]
        && !BELOW_START_IN[0] && !base_tick |=> $stable(DUTY_OUT[0]))
        else $error("remote one change not smoothed");

    // Slowed channels see one tick in four
    a_quarter_rate: assert property (quarter_tick |-> base_tick ##1 !quarter_tick [*3]) // [R8]
        else $error("slowdown tick spacing wrong");

    // A slot select change may end one slot early, so skip that slot
    a_fast_slot: assert property (base_tick && !cfg6[`FAC_SLOT_BIT] && $stable(cfg6) // [R10]
        |-> slot_cnt == SLOT_FAST_CYC - SLOT_W'(1))
        else $error("fast slot length wrong");

    a_slow_slot: assert property (base_tick && cfg6[`FAC_SLOT_BIT] && $stable(cfg6) // [R11]
        |-> slot_cnt == SLOT_SLOW_CYC - SLOT_W'(1))
        else $error("slow slot length wrong");
endmodule

// >>> testbench/fac_fan_model.sv
/*
 * Behavioural set of four fans: each spins at a rate set by a drive duty
 * and gives a speed pulse on each carry of a phase accumulator.
 * Assumes duties and the sync select come straight from the block.
 */
module fac_fan_model (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Drive duties and speed sync select
    input wire logic [2:0][7:0] duty_in,
    input wire logic [3:0] sync_in,
    // Speed pulses of inputs one to four
    output logic [3:0] tach_out
);
    // ----------------------------------------
    // Fan phases
    // ----------------------------------------
    // One accumulator per fan, carry in bit 8
    logic [3:0][8:0] phase;

    // Synced fans sit on drive three; others follow their own drive.
    // Fan four has no drive of its own, so it also hangs on drive three.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            phase <= '0;
        end else begin
            for (int k = 0; k < 4; k++) begin
                phase[k] <= {1'b0, phase[k][7:0]} + 9'(sync_in[k] ? duty_in[2] : duty_in[k > 2 ? 2 : k]);
            end
        end
    end

    // Pulse on each carry
    assign tach_out = {phase[3][8], phase[2][8], phase[1][8], phase[0][8]};
endmodule

// >>> testbench/fac_top_tb_top.sv
/*
 * Self-checking bench for the fan acoustic ramp control block.
 * Assumes the slot lengths are shortened to 8 and 12 cycles.
 */
module fac_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    // Shortened slot lengths keep ramps short
    localparam int FAST = 8;
    localparam int SLOW = 12;
    localparam int LIMIT = 60000;
    logic clk, rst, we, re, auto_m;
    logic [7:0] addr, wdat, rdat;
    logic [2:0] below, rem1, loc;
    logic [2:0][7:0] tgt, mind, duty;
    logic [3:0] sync, tach;
    int bad_count, checked, cyc, pulses;
    fac_pkg::fac_byte_t d, v, a;

    fac_top #(.SLOT_FAST_CYC(24'h8), .SLOT_SLOW_CYC(24'hc)) dut (
        .CLK_IN(clk), .SYS_RST_IN(rst), .ADDR_IN(addr), .WR_DATA_IN(wdat),
        .WR_EN_IN(we), .RD_EN_IN(re), .RD_DATA_OUT(rdat), .AUTO_MODE_IN(auto_m),
        .BELOW_START_IN(below), .CTRL_REMOTE1_IN(rem1), .CTRL_LOCAL_IN(loc),
        .TARGET_DUTY_IN(tgt), .MIN_DUTY_IN(mind), .DUTY_OUT(duty), .TACH_SYNC_OUT(sync));

    // Far side: the fans
    fac_fan_model fans (.clk_in(clk), .rst_in(rst), .duty_in(duty), .sync_in(sync), .tach_out(tach));

    // 20 MHz clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // ----------------------------------------
    // Reporting
    // ----------------------------------------
    task automatic test_done();
        $display("checked %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            bad_count++;
            $display("[ERR] %0t timeout", $time);
            test_done();
        end
    end

    // Byte compare, four-state exact
    task automatic chk_byte(input fac_pkg::fac_byte_t got, input fac_pkg::fac_byte_t exp, input string what);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // Cycle count compare against a window
    task automatic chk_cyc(input int got, input int lo, input int hi, input string what);
        checked++;
        if (got < lo || got > hi) begin
            bad_count++;
            $display("[ERR] %0t %s took %0d not %0d..%0d", $time, what, got, lo, hi);
        end
    endtask

    // ----------------------------------------
    // Register port and expectations
    // ----------------------------------------
    // One-cycle write strobe
    task automatic wr(input fac_pkg::fac_byte_t ad, input fac_pkg::fac_byte_t dt);
        @(posedge clk);
        we <= 1'b1;
        addr <= ad;
        wdat <= dt;
        @(posedge clk);
        we <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input fac_pkg::fac_byte_t ad, output fac_pkg::fac_byte_t dt);
        @(posedge clk);
        re <= 1'b1;
        addr <= ad;
        @(posedge clk);
        re <= 1'b0;
        #1 dt = rdat;
    endtask

    // Write then read with no gap between the strobes
    task automatic wr_rd(input logic [7:0] ad, input logic [7:0] dt, output logic [7:0] rv);
        @(posedge clk);
        we <= 1'b1;
        addr <= ad;
        wdat <= dt;
        @(posedge clk);
        we <= 1'b0;
        re <= 1'b1;
        @(posedge clk);
        re <= 1'b0;
        #1 rv = rdat;
    endtask

    // Step increment of each ramp code
    function automatic int step_of(input logic [2:0] code);
        case (code)
            3'h0: return 1;
            3'h1: return 2;
            3'h2: return 3;
            3'h3: return 4;
            3'h4: return 8;
            3'h5: return 12;
            3'h6: return 24;
            default: return 48;
        endcase
    endfunction

    // Drive one from zero to a random target; time must fit the step count
    task automatic ramp_case(input logic [2:0] code, input logic slotb, input logic slow, input logic [7:0] ra);
        fac_pkg::fac_byte_t t;
        int n, slot, c;
        t = 8'(60 + $urandom_range(150));
        slot = (slotb ? SLOW : FAST) * (slow ? 4 : 1);
        n = (int'(t) + step_of(code) - 1) / step_of(code);
        wr(8'h10, {slotb, 5'h00, slow, slow});
        wr(ra, {5'h00, code});
        @(posedge clk) tgt[0] <= 8'h00;
        repeat (2) @(posedge clk);
        #1 chk_byte(duty[0], 8'h00, "unsmoothed follow");
        wr(ra, {5'h01, code});
        @(posedge clk) tgt[0] <= t;
        c = 0;
        while (duty[0] !== t && c < 20000) begin
            @(posedge clk);
            #1 c++;
        end
        chk_cyc(c, (n - 1) * slot, n * slot + 2, "ramp");
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        {we, re, auto_m} = 3'h0;
        addr = 8'h00;
        wdat = 8'h00;
        {below, rem1, loc} = 9'h000;
        tgt = '0;
        mind = '0;
        bad_count = 0;
        checked = 0;
        rst = 1'b1;
        void'($urandom(32'h3371));
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        // Reset values
        rd(8'h63, d);
        chk_byte(d, 8'h00, "acou2 reset");
        chk_byte({4'h0, sync}, 8'h0c, "sync reset");
        $display("reset test done");
        // Random readback, back-to-back read idle, unmapped place
        for (int i = 0; i < 8; i++) begin
            a = (i % 3 == 0) ? 8'h10 : ((i % 3 == 1) ? 8'h62 : 8'h63);
            v = 8'($urandom);
            if (i % 2 == 1) begin
                wr_rd(a, v, d);
            end else begin
                wr(a, v);
                rd(a, d);
            end
            chk_byte(d, v, "readback");
        end
        @(posedge clk);
        #1 chk_byte(rdat, 8'h00, "read idle");
        wr(8'h77, 8'h5a);
        rd(8'h77, d);
        chk_byte(d, 8'h00, "unmapped");
        $display("register test done");
        // Ramp codes, slot select and slowdown
        @(posedge clk) rem1 <= 3'b001;
        for (int i = 0; i < 8; i++) begin
            ramp_case(3'(i), 1'b0, 1'b0, 8'h63);
        end
        ramp_case(3'h0, 1'b1, 1'b0, 8'h63);
        ramp_case(3'h7, 1'b1, 1'b0, 8'h63);
        ramp_case(3'h2, 1'b0, 1'b1, 8'h63);
        ramp_case(3'h5, 1'b1, 1'b1, 8'h63);
        // Local channel drives output one
        @(posedge clk) {rem1, loc} <= 6'h01;
        ramp_case(3'h3, 1'b1, 1'b1, 8'h62);
        $display("ramp test done");
        // Floor select for every pattern, sync bit alongside
        wr(8'h10, 8'h00);
        @(posedge clk) {rem1, loc} <= 6'h00;
        for (int f = 0; f < 8; f++) begin
            wr(8'h63, {3'(f), f[0], 4'h0});
            @(posedge clk);
            auto_m <= 1'b1;
            below <= 3'b111;
            mind <= {8'($urandom), 8'($urandom), 8'($urandom)};
            tgt <= {8'($urandom), 8'($urandom), 8'($urandom)};
            repeat (3) @(posedge clk);
            #1 chk_byte(duty[0], f[0] ? mind[0] : 8'h00, "floor one");
            chk_byte(duty[1], f[1] ? mind[1] : 8'h00, "floor two");
            chk_byte(duty[2], f[2] ? mind[2] : 8'h00, "floor three");
            chk_byte({4'h0, sync}, f[0] ? 8'h0e : 8'h0c, "sync select");
            rd(8'h30, d);
            chk_byte(d, f[0] ? mind[0] : 8'h00, "duty readback");
            @(posedge clk) below <= 3'b101;
            repeat (3) @(posedge clk);
            #1 chk_byte(duty[1], tgt[1], "above start");
            @(posedge clk) auto_m <= 1'b0;
        end
        $display("floor test done");
        // Lock makes both acoustic registers read-only
        wr(8'h62, 8'h11);
        wr(8'h63, 8'h5a);
        wr(8'h40, 8'h02);
        wr(8'h63, 8'ha5);
        wr(8'h62, 8'h33);
        wr(8'h40, 8'h00);
        rd(8'h63, d);
        chk_byte(d, 8'h5a, "locked write");
        rd(8'h62, d);
        chk_byte(d, 8'h11, "locked first");
        rd(8'h40, d);
        chk_byte(d, 8'h02, "lock sticky");
        chk_byte({4'h0, sync}, 8'h0e, "locked sync");
        // Synced fan two counts drive three's duty in 256 cycles
        pulses = 0;
        repeat (256) begin
            @(posedge clk);
            #1 pulses += int'(tach[1]);
        end
        chk_byte(8'(pulses), tgt[2], "synced speed");
        $display("lock test done");
        test_done();
    end
endmodule
